// ### hdl/kbc_host_port.sv
// Keyboard controller host mailbox, pin logic, power states and reply FIFO
`include "kbc_map.svh"

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : byte_fifo

module kbc_host_port #(
  parameter int ROM_BYTES = 2048,
  parameter int RAM_BYTES = 256,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  // Host I/O side
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic kbd_irq_out,
  output logic mouse_irq_out,
  output logic a20_gate_output,
  // Embedded CPU side
  input wire logic cpu_out_wr,
  input wire logic [7:0] cpu_out_data,
  output logic cpu_out_ready,
  input wire logic cpu_in_rd,
  output logic [7:0] cpu_input_buffer,
  input wire logic cpu_status_wr,
  input wire logic [7:0] cpu_status_data,
  output logic [7:0] cpu_status,
  input wire logic cpu_obf_clr,
  input wire logic cpu_en_flags,
  input wire logic cpu_p1_wr,
  input wire logic [7:0] cpu_p1_data,
  input wire logic cpu_p2_wr,
  input wire logic [7:0] cpu_p2_data,
  output logic [7:0] cpu_p2_q,
  input wire logic dedicated_open_drain,
  output logic test_input_zero,
  output logic test_input_one,
  output logic kbd_data_sense_bit,
  output logic mouse_data_sense_bit,
  input wire logic cpu_ibf_int_en,
  input wire logic cpu_tmr_int_en,
  input wire logic cpu_tmr_run,
  input wire logic cpu_tmr_ack,
  output logic [7:0] cpu_tmr_count,
  output logic cpu_ibf_irq,
  output logic cpu_tmr_irq,
  input wire logic cpu_halt,
  input wire logic cpu_stop,
  output logic alu_clk_en,
  output logic osc_en,
  output logic wake_call,
  output logic wake_next,
  output logic core_restart,
  input wire logic prog_ld_we,
  input wire logic [10:0] prog_ld_addr,
  input wire logic [7:0] prog_ld_data,
  input wire logic [10:0] prog_addr,
  output logic [7:0] prog_data,
  input wire logic ram_we,
  input wire logic [7:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata,
  // Dedicated port outputs a, b, c
  output logic [2:0] dedicated_out,
  output logic [2:0] dedicated_oe,
  // Keyboard and mouse open-drain pins
  input wire logic kbd_clock_pin_in,
  output logic kbd_clock_pin_out,
  output logic kbd_clock_pin_oe,
  input wire logic kbd_data_pin_in,
  output logic kbd_data_pin_out,
  output logic kbd_data_pin_oe,
  input wire logic mouse_clock_pin_in,
  output logic mouse_clock_pin_out,
  output logic mouse_clock_pin_oe,
  input wire logic mouse_data_pin_in,
  output logic mouse_data_pin_out,
  output logic mouse_data_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic sel_data;
  logic sel_cmd;
  logic host_in_wr;
  logic host_out_rd;
  logic host_st_rd;
  logic [7:0] in_buf_ff;
  logic [7:0] out_buf_ff;
  logic [7:0] host_rdata_ff;
  logic obf_ff;
  logic ibf_ff;
  logic cd_ff;
  logic [7:0] ud_ff;
  logic gate_ff;
  logic [7:0] p1_ff;
  logic [7:0] p2_ff;
  logic [7:0] status;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic obf_load;

  // At most one decoded strobe per host byte cycle; addresses other than the data and command ports decode none
  assign sel_data = (host_addr == `KBC_DATA_PORT);
  assign sel_cmd = (host_addr == `KBC_CMD_PORT);
  assign host_in_wr = host_wr && (sel_data || sel_cmd);
  assign host_out_rd = host_rd && sel_data;
  assign host_st_rd = host_rd && sel_cmd;

  assign status = (ud_ff & `KBC_ST_UD_MASK) | {4'h0, cd_ff, 1'b0, ibf_ff, obf_ff};
  assign cpu_status = status;
  assign cpu_input_buffer = in_buf_ff;
  assign host_rdata = host_rdata_ff;
  assign cpu_p2_q = p2_ff;

  always_ff @(posedge clk) begin
    if (host_in_wr) begin
      in_buf_ff <= host_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cd_ff <= 1'b0;
    end else if (host_in_wr) begin
      cd_ff <= host_addr[`KBC_ADDR_SEL_BIT];
    end
  end

  // A host write in the same cycle as the CPU read keeps the flag set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ibf_ff <= 1'b0;
    end else if (host_in_wr) begin
      ibf_ff <= 1'b1;
    end else if (cpu_in_rd) begin
      ibf_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ud_ff <= `KBC_ST_RESET;
    end else if (cpu_status_wr) begin
      ud_ff <= cpu_status_data & `KBC_ST_UD_MASK;
    end
  end

  // Replies queue in the FIFO; one moves up whenever the host buffer is free
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) reply_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(cpu_out_wr),
    .in_ready(cpu_out_ready),
    .in_data(cpu_out_data),
    .out_valid(fifo_valid),
    .out_ready(!obf_ff),
    .out_data(fifo_data)
  );
  assign obf_load = fifo_valid && !obf_ff;

  always_ff @(posedge clk) begin
    if (obf_load) begin
      out_buf_ff <= fifo_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      obf_ff <= 1'b0;
    end else if (obf_load) begin
      obf_ff <= 1'b1;
    end else if ((host_out_rd && gate_ff) || cpu_obf_clr) begin
      obf_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_rdata_ff <= 8'h00;
    end else if (host_out_rd) begin
      host_rdata_ff <= out_buf_ff;
    end else if (host_st_rd) begin
      host_rdata_ff <= status;
    end
  end

  // Flag gating can only be turned off again by reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate_ff <= 1'b0;
    end else if (cpu_en_flags) begin
      gate_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      p1_ff <= `KBC_P1_RESET;
      p2_ff <= `KBC_P2_RESET;
    end else begin
      if (cpu_p1_wr) begin
        p1_ff <= cpu_p1_data;
      end
      if (cpu_p2_wr) begin
        p2_ff <= cpu_p2_data;
      end
    end
  end

  // Host interrupt lines, registered to keep them glitch free
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      kbd_irq_out <= 1'b0;
      mouse_irq_out <= 1'b0;
      a20_gate_output <= 1'b0;
    end else begin
      kbd_irq_out <= gate_ff ? (p2_ff[`KBC_P2_KBD_IRQ_OUT] && obf_ff)
                             : p2_ff[`KBC_P2_KBD_IRQ_OUT];
      mouse_irq_out <= gate_ff ? (p2_ff[`KBC_P2_MOUSE_IRQ_OUT] && !ibf_ff)
                               : p2_ff[`KBC_P2_MOUSE_IRQ_OUT];
      a20_gate_output <= p2_ff[`KBC_P2_A20];
    end
  end

  // Dedicated outputs: no direction or inversion setting reaches them
  logic [2:0] ded_bit;
  assign ded_bit = {p1_ff[`KBC_P1_DED_A], p1_ff[`KBC_P1_DED_B], p1_ff[`KBC_P1_DED_C]};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ded
      logic prev_ff;
      logic [6:0] pull_cnt_ff;
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          prev_ff <= 1'b1;
          pull_cnt_ff <= '0;
        end else begin
          prev_ff <= ded_bit[gi];
          if (ded_bit[gi] && !prev_ff) begin
            pull_cnt_ff <= 7'(`KBC_PULLUP_CYCLES);
          end else if (!ded_bit[gi]) begin
            pull_cnt_ff <= '0;
          end else if (pull_cnt_ff != '0) begin
            pull_cnt_ff <= pull_cnt_ff - 1'b1;
          end
        end
      end
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          dedicated_out[gi] <= 1'b0;
          dedicated_oe[gi] <= 1'b0;
        end else begin
          dedicated_out[gi] <= ded_bit[gi] && !dedicated_open_drain;
          // Rising edge drives at once; the counter only loads on this same edge
          dedicated_oe[gi] <= !ded_bit[gi] ||
                              (!dedicated_open_drain &&
                               (pull_cnt_ff > 7'h01 || !prev_ff));
        end
      end
    end
  endgenerate

  // Pins only ever pull low; a port bit of one drives the pin to zero
  assign kbd_clock_pin_out = 1'b0;
  assign kbd_data_pin_out = 1'b0;
  assign mouse_clock_pin_out = 1'b0;
  assign mouse_data_pin_out = 1'b0;
  assign kbd_clock_pin_oe = p2_ff[`KBC_P2_KBD_CLOCK_PIN];
  assign kbd_data_pin_oe = p2_ff[`KBC_P2_KBD_DATA_PIN];
  assign mouse_clock_pin_oe = p2_ff[`KBC_P2_MCLK];
  assign mouse_data_pin_oe = p2_ff[`KBC_P2_MOUSE_DATA_PIN];

  logic [3:0] pin_meta_ff;
  logic [3:0] pin_sync_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta_ff <= 4'h0;
      pin_sync_ff <= 4'h0;
    end else begin
      pin_meta_ff <= {mouse_data_pin_in, mouse_clock_pin_in, kbd_data_pin_in, kbd_clock_pin_in};
      pin_sync_ff <= pin_meta_ff;
    end
  end
  assign test_input_zero = pin_sync_ff[0];
  assign kbd_data_sense_bit = pin_sync_ff[1];
  assign test_input_one = pin_sync_ff[2];
  assign mouse_data_sense_bit = pin_sync_ff[3];

  // Power states
  kbc_pkg::pwr_state_t pwr_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr_ff <= kbc_pkg::PWR_RUN;
    end else begin
      case (pwr_ff)
        kbc_pkg::PWR_RUN: begin
          if (cpu_stop) begin
            pwr_ff <= kbc_pkg::PWR_STOP;
          end else if (cpu_halt) begin
            pwr_ff <= kbc_pkg::PWR_HALT;
          end
        end
        kbc_pkg::PWR_HALT, kbc_pkg::PWR_STOP: begin
          if (host_in_wr) begin
            pwr_ff <= kbc_pkg::PWR_RUN;
          end
        end
        default: pwr_ff <= kbc_pkg::PWR_RUN;
      endcase
    end
  end
  assign alu_clk_en = (pwr_ff == kbc_pkg::PWR_RUN);
  assign osc_en = (pwr_ff != kbc_pkg::PWR_STOP);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_call <= 1'b0;
      wake_next <= 1'b0;
      core_restart <= 1'b1;
    end else begin
      wake_call <= (pwr_ff != kbc_pkg::PWR_RUN) && host_in_wr && cpu_ibf_int_en;
      wake_next <= (pwr_ff != kbc_pkg::PWR_RUN) && host_in_wr && !cpu_ibf_int_en;
      core_restart <= 1'b0;
    end
  end

  // Timer keeps counting in halt, stops with the oscillator
  logic tmr_ovf_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_tmr_count <= 8'h00;
      tmr_ovf_ff <= 1'b0;
    end else begin
      if (cpu_tmr_run && osc_en) begin
        cpu_tmr_count <= cpu_tmr_count + 8'h01;
      end
      if (cpu_tmr_run && osc_en && cpu_tmr_count == 8'hFF) begin
        tmr_ovf_ff <= 1'b1;
      end else if (cpu_tmr_ack) begin
        tmr_ovf_ff <= 1'b0;
      end
    end
  end
  assign cpu_ibf_irq = ibf_ff && cpu_ibf_int_en;
  assign cpu_tmr_irq = tmr_ovf_ff && cpu_tmr_int_en;

  // Program store is filled by the loader port; data RAM is plain
  logic [7:0] rom_mem [ROM_BYTES];
  logic [7:0] ram_mem [RAM_BYTES];
  always_ff @(posedge clk) begin
    if (prog_ld_we) begin
      rom_mem[prog_ld_addr] <= prog_ld_data;
    end
    prog_data <= rom_mem[prog_addr];
  end
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram_mem[ram_addr] <= ram_wdata;
    end
    ram_rdata <= ram_mem[ram_addr];
  end

  data_write_a: assert property (host_wr && sel_data |=> ibf_ff && !cd_ff)
    else $error("data port write did not mark data");
  cmd_write_a: assert property (host_wr && sel_cmd |=> ibf_ff && cd_ff)
    else $error("command port write did not mark command");
  data_read_a: assert property (host_out_rd && gate_ff && !obf_load |=> !obf_ff ##1 !kbd_irq_out)
    else $error("gated data read did not clear output full");
  status_read_a: assert property (host_st_rd |=> host_rdata == $past(status))
    else $error("status read returned wrong value");
  load_obf_a: assert property (obf_load |=> obf_ff && out_buf_ff == $past(fifo_data))
    else $error("reply byte not loaded");
  kbd_irq_out_gate_a: assert property (gate_ff && !p2_ff[`KBC_P2_KBD_IRQ_OUT] |=> !kbd_irq_out)
    else $error("keyboard irq not forced low");
  mouse_irq_out_gate_a: assert property (gate_ff && p2_ff[`KBC_P2_MOUSE_IRQ_OUT] |=> mouse_irq_out == !$past(ibf_ff))
    else $error("mouse irq not inverted input full");
  kbd_irq_out_direct_a: assert property (!gate_ff && !cpu_en_flags |=> kbd_irq_out == $past(p2_ff[`KBC_P2_KBD_IRQ_OUT]))
    else $error("keyboard irq not following port bit");
  ibf_clear_a: assert property (cpu_in_rd && !host_in_wr |=> !ibf_ff && !cpu_ibf_irq)
    else $error("input full not cleared by CPU read");
  halt_wake_a: assert property (pwr_ff == kbc_pkg::PWR_HALT && host_in_wr |=> alu_clk_en)
    else $error("halt not left on host write");
  kbd_pin_a: assert property (kbd_clock_pin_oe == p2_ff[`KBC_P2_KBD_CLOCK_PIN] && !kbd_clock_pin_out)
    else $error("keyboard clock pin wrongly driven");
  ded_drive_a: assert property (!dedicated_open_drain && $rose(ded_bit[0]) |=> dedicated_oe[0])
    else $error("dedicated output not driven high on rise");

endmodule : kbc_host_port

// ### hdl/kbc_map.svh
// Offsets, field positions, reset values and timing counts of the keyboard host port
`ifndef KBC_MAP_SVH
`define KBC_MAP_SVH

// Host I/O addresses
`define KBC_DATA_PORT 8'h60
`define KBC_CMD_PORT 8'h64
`define KBC_ADDR_SEL_BIT 2

// Status register fields
`define KBC_ST_OBF 0
`define KBC_ST_IBF 1
`define KBC_ST_CD 3
`define KBC_ST_UD_MASK 8'hF4
`define KBC_ST_RESET 8'h00

// Second CPU port: bit positions and reset value
`define KBC_P2_A20 1
`define KBC_P2_MOUSE_DATA_PIN 2
`define KBC_P2_MCLK 3
`define KBC_P2_KBD_IRQ_OUT 4
`define KBC_P2_MOUSE_IRQ_OUT 5
`define KBC_P2_KBD_CLOCK_PIN 6
`define KBC_P2_KBD_DATA_PIN 7
`define KBC_P2_RESET 8'hCF

// First CPU port: dedicated outputs c, b, a
`define KBC_P1_DED_C 2
`define KBC_P1_DED_B 6
`define KBC_P1_DED_A 7
`define KBC_P1_RESET 8'hFF

// Active pull-up window on the dedicated outputs
`define KBC_CLK_PERIOD_NS 8
`define KBC_PULLUP_TIME_NS 500
`define KBC_PULLUP_CYCLES (`KBC_PULLUP_TIME_NS / `KBC_CLK_PERIOD_NS)

`endif

// ### hdl/kbc_pkg.sv
// Types shared by the keyboard host port
package kbc_pkg;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_HALT,
    PWR_STOP
  } pwr_state_t;

endpackage : kbc_pkg

// ### test/host_lpc_model.sv
// Host bus controller model issuing single-byte I/O reads and writes
module host_lpc_model (
  input wire logic clk,
  output logic host_wr,
  output logic host_rd,
  output logic [7:0] host_addr,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 8'h00;
    host_wdata = 8'h00;
  end

  // Released bus shows the inverse, so a stale value never passes for fresh
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge clk);
    host_wr = 1'b0;
    host_addr = ~a;
    host_wdata = ~d;
  endtask : write

  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge clk);
    host_rd = 1'b0;
    host_addr = ~a;
    d = host_rdata;
  endtask : read
endmodule : host_lpc_model

// ### test/keyboard_ctrl_host_interface_bench.sv
// Self-checking bench of the keyboard host port
module keyboard_ctrl_host_interface_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst_n, host_wr, host_rd, cpu_out_wr, cpu_out_ready, cpu_in_rd, cpu_status_wr;
  logic cpu_obf_clr, cpu_en_flags, cpu_p1_wr, cpu_p2_wr, dedicated_open_drain;
  logic test_input_zero, test_input_one, kbd_data_sense_bit, mouse_data_sense_bit;
  logic cpu_ibf_int_en, cpu_tmr_int_en, cpu_tmr_run, cpu_tmr_ack, cpu_ibf_irq, cpu_tmr_irq;
  logic cpu_halt, cpu_stop, alu_clk_en, osc_en, wake_call, wake_next, core_restart;
  logic prog_ld_we, ram_we, kbd_irq_out, mouse_irq_out, a20_gate_output;
  logic [7:0] host_addr, host_wdata, host_rdata, cpu_out_data, cpu_input_buffer;
  logic [7:0] cpu_status_data, cpu_status, cpu_p1_data, cpu_p2_data, cpu_p2_q, cpu_tmr_count;
  logic [7:0] prog_ld_data, prog_data, ram_addr, ram_wdata, ram_rdata;
  logic [10:0] prog_ld_addr, prog_addr;
  logic [2:0] dedicated_out, dedicated_oe;
  logic kbd_clock_pin_out, kbd_clock_pin_oe, kbd_data_pin_out, kbd_data_pin_oe;
  logic mouse_clock_pin_out, mouse_clock_pin_oe, mouse_data_pin_out, mouse_data_pin_oe;
  // Board pull-ups hold a released pin high
  wire logic kbd_clock_pin_in = kbd_clock_pin_oe ? kbd_clock_pin_out : 1'b1;
  wire logic kbd_data_pin_in = kbd_data_pin_oe ? kbd_data_pin_out : 1'b1;
  wire logic mouse_clock_pin_in = mouse_clock_pin_oe ? mouse_clock_pin_out : 1'b1;
  wire logic mouse_data_pin_in = mouse_data_pin_oe ? mouse_data_pin_out : 1'b1;
  int error_cnt, samples_checked, cycles, n;
  logic [7:0] v;
  logic saw_call, saw_next;

  kbc_host_port i_dut (.*);
  host_lpc_model i_host (.clk(clk), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cycles++;
    if (wake_call === 1'b1) saw_call = 1'b1;
    if (wake_next === 1'b1) saw_next = 1'b1;
    // Whole run needs a few hundred cycles
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h wanted %h", $time, got, exp);
    end
  endtask : chk

  task step(input int k);
    repeat (k) @(negedge clk);
  endtask : step

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : pulse

  task wr_p2(input logic [7:0] d);
    cpu_p2_data = d;
    pulse(cpu_p2_wr);
    step(4);
  endtask : wr_p2

  task wr_p1(input logic [7:0] d);
    cpu_p1_data = d;
    pulse(cpu_p1_wr);
    step(2);
  endtask : wr_p1

  task do_reset;
    rst_n = 1'b0;
    step(4);
    chk(core_restart, 8'h01);
    rst_n = 1'b1;
    step(1);
    chk(cpu_status, 8'h00);
    chk(kbd_irq_out, 8'h00);
    chk(core_restart, 8'h00);
  endtask : do_reset

  initial begin
    {rst_n, cpu_out_wr, cpu_in_rd, cpu_status_wr, cpu_obf_clr, cpu_en_flags} = '0;
    {cpu_p1_wr, cpu_p2_wr, dedicated_open_drain, cpu_ibf_int_en, cpu_tmr_int_en} = '0;
    {cpu_tmr_run, cpu_tmr_ack, cpu_halt, cpu_stop, prog_ld_we, ram_we} = '0;
    {cpu_out_data, cpu_status_data, cpu_p1_data, cpu_p2_data, prog_ld_data} = '0;
    {ram_addr, ram_wdata, prog_ld_addr, prog_addr} = '0;
    {saw_call, saw_next} = '0;
    error_cnt = 0;
    samples_checked = 0;
    cycles = 0;
    step(1);
    do_reset();
    chk({kbd_clock_pin_oe, kbd_data_pin_oe, mouse_clock_pin_oe, mouse_data_pin_oe}, 8'h0F);
    // Host writes, flags and the CPU side
    i_host.write(8'h60, 8'hA5);
    step(2);
    chk(cpu_status & 8'h0B, 8'h02);
    chk(cpu_input_buffer, 8'hA5);
    pulse(cpu_in_rd);
    step(2);
    chk(cpu_status & 8'h0B, 8'h00);
    i_host.write(8'h64, 8'h5A);
    i_host.write(8'h61, 8'h11);
    step(2);
    chk(cpu_status & 8'h0B, 8'h0A);
    chk(cpu_input_buffer, 8'h5A);
    i_host.read(8'h64, v);
    chk(v, 8'h0A);
    step(2);
    chk(cpu_status, 8'h0A);
    for (int i = 0; i < 4; i++) begin
      wr_p2({2'b11, i[1], i[0], 2'b11, i[1], 1'b1});
      chk({kbd_irq_out, mouse_irq_out, a20_gate_output}, {5'h0, i[0], i[1], i[1]});
    end
    wr_p2(8'h0F);
    chk({kbd_clock_pin_oe, kbd_data_pin_oe, mouse_clock_pin_oe, mouse_data_pin_oe,
      test_input_zero, kbd_data_sense_bit, test_input_one, mouse_data_sense_bit}, 8'h3C);
    wr_p2(8'hC3);
    chk(cpu_p2_q, 8'hC3);
    chk({kbd_clock_pin_oe, kbd_data_pin_oe, mouse_clock_pin_oe, mouse_data_pin_oe,
      test_input_zero, kbd_data_sense_bit, test_input_one, mouse_data_sense_bit}, 8'hC3);
    chk({kbd_clock_pin_out, kbd_data_pin_out, mouse_clock_pin_out, mouse_data_pin_out}, 0);
    // Ungated reply path
    cpu_out_data = 8'h3C;
    pulse(cpu_out_wr);
    step(4);
    chk(cpu_status[0], 8'h01);
    i_host.read(8'h60, v);
    chk(v, 8'h3C);
    step(2);
    chk(cpu_status[0], 8'h01);
    pulse(cpu_obf_clr);
    step(2);
    chk(cpu_status[0], 8'h00);
    // Gated flags; input byte of the command write is still pending
    pulse(cpu_en_flags);
    wr_p2(8'hFF);
    chk(mouse_irq_out, 8'h00);
    pulse(cpu_in_rd);
    step(3);
    chk(mouse_irq_out, 8'h01);
    i_host.write(8'h60, 8'h77);
    step(3);
    chk(mouse_irq_out, 8'h00);
    pulse(cpu_in_rd);
    n = 0;
    while (cpu_out_ready === 1'b1 && n < 40) begin
      cpu_out_data = n[7:0];
      cpu_out_wr = 1'b1;
      n++;
      step(1);
    end
    cpu_out_wr = 1'b0;
    chk(n[7:0], 8'd17);
    step(3);
    chk(kbd_irq_out, 8'h01);
    wr_p2(8'hEF);
    chk(kbd_irq_out, 8'h00);
    wr_p2(8'hFF);
    for (int i = 0; i < 17; i++) begin
      for (int k = 0; k < 20 && cpu_status[0] !== 1'b1; k++) step(1);
      i_host.read(8'h60, v);
      chk(v, i[7:0]);
    end
    step(3);
    chk({cpu_status[0], kbd_irq_out}, 8'h00);
    // Dedicated outputs, push-pull then open-drain
    wr_p1(8'h00);
    chk({dedicated_oe, dedicated_out}, 8'h38);
    wr_p1(8'hFF);
    step(40);
    chk({dedicated_oe, dedicated_out}, 8'h3F);
    step(40);
    chk(dedicated_oe, 8'h00);
    dedicated_open_drain = 1'b1;
    wr_p1(8'h00);
    chk({dedicated_oe, dedicated_out}, 8'h38);
    wr_p1(8'hFF);
    chk(dedicated_oe, 8'h00);
    // Power-down entry and host-write wake
    cpu_ibf_int_en = 1'b1;
    pulse(cpu_halt);
    step(2);
    chk({alu_clk_en, osc_en}, 8'h01);
    i_host.write(8'h60, 8'h01);
    step(3);
    chk({alu_clk_en, saw_call, cpu_ibf_irq}, 8'h07);
    cpu_ibf_int_en = 1'b0;
    pulse(cpu_in_rd);
    pulse(cpu_stop);
    step(2);
    chk({alu_clk_en, osc_en}, 8'h00);
    i_host.write(8'h64, 8'h02);
    step(3);
    chk({alu_clk_en, osc_en, saw_next}, 8'h07);
    // Timer overflow raises its interrupt after 256 counts
    cpu_tmr_int_en = 1'b1;
    cpu_tmr_run = 1'b1;
    step(256);
    cpu_tmr_run = 1'b0;
    chk(cpu_tmr_count, 8'h00);
    chk(cpu_tmr_irq, 8'h01);
    pulse(cpu_tmr_ack);
    step(1);
    chk(cpu_tmr_irq, 8'h00);
    // Top locations of the program store and data RAM
    prog_ld_addr = 11'h7FF;
    prog_ld_data = 8'hC3;
    pulse(prog_ld_we);
    prog_addr = 11'h7FF;
    ram_addr = 8'hFF;
    ram_wdata = 8'h96;
    pulse(ram_we);
    step(1);
    chk(prog_data, 8'hC3);
    chk(ram_rdata, 8'h96);
    cpu_status_data = 8'hFF;
    pulse(cpu_status_wr);
    step(2);
    chk(cpu_status & 8'hF4, 8'hF4);
    do_reset();
    give_verdict();
  end
endmodule : keyboard_ctrl_host_interface_bench
